// file: common/rmc_pkg.sv
// shared constants and carrier types of the radio modem configuration block
package rmc_pkg;
	// command codes, also the setting offsets
	localparam logic [7:0] CMD_DEST     = 8'h00;
	localparam logic [7:0] CMD_LEAD     = 8'h04;
	localparam logic [7:0] CMD_TMO      = 8'h06;
	localparam logic [7:0] CMD_EXIT     = 8'h09;
	localparam logic [7:0] CMD_ESC      = 8'h13;
	localparam logic [7:0] CMD_FWVER    = 8'h14;
	localparam logic [7:0] CMD_HRATE    = 8'h15;
	localparam logic [7:0] CMD_OUT1     = 8'h1f;
	localparam logic [7:0] CMD_OUT2     = 8'h28;
	localparam logic [7:0] CMD_RSSI     = 8'h36;
	localparam logic [7:0] CMD_AIR      = 8'h39;
	localparam logic [7:0] CMD_KEY      = 8'h3c;
	localparam logic [7:0] CMD_FMT      = 8'h3d;
	// reset values
	localparam logic [15:0] RST_DEST    = 16'h0000;
	localparam logic [15:0] RST_LEAD    = 16'h000a;
	localparam logic [15:0] RST_TMO     = 16'h00c8;
	localparam logic [7:0]  RST_ESC     = 8'h2b;
	localparam logic [31:0] RST_HRATE   = 32'h0000_0003;
	localparam logic [2:0]  RST_OUT1    = 3'h0;
	localparam logic [2:0]  RST_OUT2    = 3'h2;
	localparam logic        RST_AIR     = 1'b1;
	localparam logic [1:0]  RST_FMT     = 2'h1;
	// limits
	localparam logic [15:0] TMO_MIN     = 16'h0002;
	localparam logic [7:0]  ESC_MIN     = 8'h20;
	localparam logic [7:0]  ESC_MAX     = 8'h7f;
	localparam logic [31:0] CODE_MAX    = 32'h0000_0008;
	localparam logic [31:0] LIT_MIN     = 32'h0000_0039;
	localparam logic [31:0] LIT_MAX     = 32'h001c_9c38;
	localparam logic [2:0]  OUT1_MAX    = 3'h4;
	localparam logic [2:0]  OUT2_MAX    = 3'h4;
	localparam logic [2:0]  OUT2_RSVD   = 3'h3;
	localparam logic [1:0]  FMT_MAX     = 2'h2;
	localparam logic [15:0] ADDR_ALL    = 16'hffff;
	localparam logic [15:0] RSSI_NONE   = 16'h8000;
	// reply widths in bytes
	localparam logic [2:0]  LEN1        = 3'd1;
	localparam logic [2:0]  LEN2        = 3'd2;
	localparam logic [2:0]  LEN4        = 3'd4;
	// timing
	localparam int          CLK_HZ      = 40_000_000;
	localparam int          TICK_MS     = 100;
	localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
	localparam int          OVERSAMPLE  = 16;
	localparam logic [31:0] UART_REF    = 32'(CLK_HZ / OVERSAMPLE);
	localparam logic [15:0] GUARD_AFTER = 16'h000a;
	// over-the-air rates in bit/s
	localparam logic [31:0] AIR_SLOW    = 32'd9600;
	localparam logic [31:0] AIR_FAST    = 32'd115200;
	typedef enum logic [1:0] {FMT_DEC_UNITS, FMT_HEX, FMT_DEC} rmc_fmt_t;
	typedef struct packed {
		logic        write;
		logic [7:0]  code;
		logic [31:0] data;
	} rmc_cmd_t;
	typedef struct packed {
		logic        ok;
		logic [2:0]  bytes;
		rmc_fmt_t    fmt;
		logic [31:0] data;
	} rmc_rsp_t;
	typedef struct packed {
		logic [15:0] vendor;
		logic [3:0]  channel;
		logic [15:0] dest;
		logic [7:0]  power;
	} rmc_pkt_t;
endpackage : rmc_pkg

// file: rtl/rmc_config.sv
// command interpreter and settings of the radio modem serial side
//
// Notes on behaviour
// - host rate above 0x38 is literal bit/s
// - codes 0..8 standard rates, literals to 0x1C9C38
// - literal rate stored as nearest achievable rate
// - host rate resets to code 3, four-byte reply
// - air rate 0 or 1, default 1
// - lead guard silence 0..0xFFFF, default 0x0A
// - escape char 0x20..0x7F, sequence enters command mode
// - output two: rx, high, low, rx-addressed
// - number format 0, 1 or 2, default 1
// - version and key always hexadecimal
// - exit command 0x09 leaves command mode
// - output one: cts, 485 low, high, 485 high, low
// - inactivity timeout in 100 ms units exits
// - signal strength magnitude, read-only, two bytes
// - signal strength reply format follows setting
// - 0x8000 before any packet received
// - vendor, channel, address filters in turn
// - all-ones own and mask match destination
// - own address is receive address unless all-ones
// - all-ones destination broadcasts
// - new host rate applies with exit reply
// - host rate 0x09..0x38 rejected
// - lead guard silence before escape, fixed one second after
`timescale 1ns/1ps
module rmc_config #(
	parameter int TICK_CYCLES = rmc_pkg::TICK_CYC
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	output logic                  pay_valid,
	output logic [7:0]            pay_data,
	input  wire logic             cmd_valid,
	input  wire rmc_pkg::rmc_cmd_t cmd,
	output logic                  rsp_valid,
	output rmc_pkg::rmc_rsp_t     rsp,
	output logic                  cmd_mode,
	output logic [31:0]           host_divisor,
	output logic [31:0]           air_rate,
	input  wire logic             pkt_valid,
	input  wire rmc_pkg::rmc_pkt_t pkt,
	input  wire logic [15:0]      own_address,
	input  wire logic [15:0]      address_mask,
	input  wire logic [15:0]      network_vendor_number,
	input  wire logic [3:0]       hopping_channel,
	output logic                  pkt_accept,
	output logic [15:0]           tx_address,
	output logic                  tx_broadcast,
	input  wire logic             host_stop,
	input  wire logic             tx_active,
	input  wire logic             rx_active,
	output logic                  flow_output_one,
	output logic                  status_output_two
);
	import rmc_pkg::*;

	typedef enum logic [1:0] {ST_DATA, ST_ESC, ST_CMD} rmc_state_t;

	// standard rate table, code to bit/s
	function automatic logic [31:0] code_rate(input logic [3:0] c);
		unique case (c)
			4'd0: code_rate = 32'd1200;
			4'd1: code_rate = 32'd2400;
			4'd2: code_rate = 32'd4800;
			4'd3: code_rate = 32'd9600;
			4'd4: code_rate = 32'd19200;
			4'd5: code_rate = 32'd38400;
			4'd6: code_rate = 32'd57600;
			4'd7: code_rate = 32'd115200;
			default: code_rate = 32'd230400;
		endcase
	endfunction : code_rate

	// rounded division, used for divisor and its achieved rate
	function automatic logic [31:0] rdiv(input logic [31:0] n, input logic [31:0] d);
		rdiv = (n + (d >> 1)) / d;
	endfunction : rdiv

	rmc_state_t  state;
	rmc_state_t  next_state;
	logic [15:0] destination_address;
	logic [15:0] lead_guard_time;
	logic [15:0] command_mode_timeout;
	logic [7:0]  escape_character;
	logic [31:0] host_rate_select;
	logic [2:0]  flow_output_one_select;
	logic [2:0]  status_output_two_select;
	logic        air_rate_select;
	logic [1:0]  number_format;
	logic [7:0]  rssi_mag;
	logic        rssi_seen;
	logic        rate_pending;
	logic        last_accept;
	logic [31:0] tick_cnt;
	logic        tick;
	logic [15:0] silence;
	logic [15:0] idle;

	// tick divider: one pulse per 100 ms
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (reset || tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 32'd1;
	end

	// silence and inactivity, both saturating in ticks
	wire host_seen = rx_valid || (cmd_valid && state == ST_CMD);
	always_ff @(posedge clk) begin
		if (reset || rx_valid)
			silence <= '0;
		else if (tick && silence != '1)
			silence <= silence + 16'd1;
	end
	always_ff @(posedge clk) begin
		if (reset || host_seen || state != ST_CMD)
			idle <= '0;
		else if (tick && idle != '1)
			idle <= idle + 16'd1;
	end

	// command decode
	wire take      = cmd_valid && state == ST_CMD;
	wire [31:0] wd = cmd.data;
	wire is_exit   = take && cmd.code == CMD_EXIT;
	wire lit_rate  = wd > CODE_MAX;
	wire rate_ok   = wd <= CODE_MAX || (wd >= LIT_MIN && wd <= LIT_MAX);
	wire [31:0] req_rate  = lit_rate ? wd : code_rate(wd[3:0]);
	wire [31:0] new_div   = rdiv(UART_REF, req_rate);
	wire [31:0] got_rate  = rdiv(UART_REF, new_div);
	wire [31:0] rate_keep = lit_rate ? got_rate : wd;
	wire [31:0] cur_rate  = host_rate_select > CODE_MAX ? host_rate_select
	                      : code_rate(host_rate_select[3:0]);

	// value check for each writable setting
	logic wr_ok;
	always_comb begin
		unique case (cmd.code)
			CMD_DEST, CMD_LEAD: wr_ok = wd[31:16] == '0;
			CMD_TMO:   wr_ok = wd[31:16] == '0 && wd[15:0] >= TMO_MIN;
			CMD_ESC:   wr_ok = wd[31:8] == '0 && wd[7:0] >= ESC_MIN && wd[7:0] <= ESC_MAX;
			CMD_HRATE: wr_ok = rate_ok;
			CMD_OUT1:  wr_ok = wd[31:3] == '0 && wd[2:0] <= OUT1_MAX;
			CMD_OUT2:  wr_ok = wd[31:3] == '0 && wd[2:0] <= OUT2_MAX && wd[2:0] != OUT2_RSVD;
			CMD_AIR:   wr_ok = wd[31:1] == '0;
			CMD_FMT:   wr_ok = wd[31:2] == '0 && wd[1:0] <= FMT_MAX;
			default:   wr_ok = 1'b0; // read-only or unknown
		endcase
	end
	wire do_wr = take && cmd.write && wr_ok;

	// settings, updated only by an accepted write
	always_ff @(posedge clk) begin
		if (reset) begin
			destination_address      <= RST_DEST;
			lead_guard_time          <= RST_LEAD;
			command_mode_timeout     <= RST_TMO;
			escape_character         <= RST_ESC;
			host_rate_select         <= RST_HRATE;
			flow_output_one_select   <= RST_OUT1;
			status_output_two_select <= RST_OUT2;
			air_rate_select          <= RST_AIR;
			number_format            <= RST_FMT;
		end else if (do_wr) begin
			unique case (cmd.code)
				CMD_DEST:  destination_address      <= wd[15:0];
				CMD_LEAD:  lead_guard_time          <= wd[15:0];
				CMD_TMO:   command_mode_timeout     <= wd[15:0];
				CMD_ESC:   escape_character         <= wd[7:0];
				CMD_HRATE: host_rate_select         <= rate_keep;
				CMD_OUT1:  flow_output_one_select   <= wd[2:0];
				CMD_OUT2:  status_output_two_select <= wd[2:0];
				CMD_AIR:   air_rate_select          <= wd[0];
				default:   number_format            <= wd[1:0];
			endcase
		end
	end

	// divisor follows the stored rate only from the edge that presents the exit reply
	always_ff @(posedge clk) begin
		if (reset) begin
			rate_pending <= 1'b0;
			host_divisor <= rdiv(UART_REF, code_rate(RST_HRATE[3:0]));
		end else if (do_wr && cmd.code == CMD_HRATE) begin
			rate_pending <= 1'b1;
		end else if (is_exit && rate_pending) begin
			rate_pending <= 1'b0;
			host_divisor <= rdiv(UART_REF, cur_rate);
		end
	end
	assign air_rate = air_rate_select ? AIR_FAST : AIR_SLOW;

	// mode sequencing: guard, escape, guard
	wire lead_ok  = silence >= lead_guard_time;
	wire esc_hit  = rx_valid && rx_data == escape_character && lead_ok;
	wire tmo_hit  = idle >= command_mode_timeout && !host_seen;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_DATA: if (esc_hit) next_state = ST_ESC;
			ST_ESC: begin
				if (rx_valid)
					next_state = ST_DATA;
				else if (silence >= GUARD_AFTER)
					next_state = ST_CMD;
			end
			ST_CMD: begin
				if (is_exit || tmo_hit)
					next_state = ST_DATA;
			end
			default: next_state = ST_DATA;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset)
			state <= ST_DATA;
		else
			state <= next_state;
	end
	assign cmd_mode = (state == ST_CMD);

	// payload pass-through; host bytes in command mode are not payload
	always_ff @(posedge clk) begin
		if (reset) begin
			pay_valid <= 1'b0;
			pay_data  <= '0;
		end else begin
			pay_valid <= rx_valid && state != ST_CMD;
			if (rx_valid)
				pay_data <= rx_data;
		end
	end

	// reply assembly
	wire [15:0] rssi_word = rssi_seen ? {8'h00, rssi_mag} : RSSI_NONE;
	wire hex_only = cmd.code == CMD_FWVER || cmd.code == CMD_KEY;
	rmc_rsp_t next_rsp;
	always_comb begin
		next_rsp.ok    = !cmd.write || wr_ok || cmd.code == CMD_EXIT;
		next_rsp.bytes = LEN2;
		next_rsp.fmt   = hex_only ? FMT_HEX : rmc_fmt_t'(number_format);
		next_rsp.data  = '0;
		unique case (cmd.code)
			CMD_DEST:  next_rsp.data = {16'h0, destination_address};
			CMD_LEAD:  next_rsp.data = {16'h0, lead_guard_time};
			CMD_TMO:   next_rsp.data = {16'h0, command_mode_timeout};
			CMD_ESC:   next_rsp.data = {24'h0, escape_character};
			CMD_OUT1:  next_rsp.data = {29'h0, flow_output_one_select};
			CMD_OUT2:  next_rsp.data = {29'h0, status_output_two_select};
			CMD_AIR:   next_rsp.data = {31'h0, air_rate_select};
			CMD_FMT:   next_rsp.data = {30'h0, number_format};
			CMD_HRATE: next_rsp.data = host_rate_select;
			CMD_RSSI:  next_rsp.data = {16'h0, rssi_word};
			default:   next_rsp.data = '0;
		endcase
		if (cmd.code == CMD_HRATE)
			next_rsp.bytes = LEN4;
		else if (cmd.code inside {CMD_ESC, CMD_OUT1, CMD_OUT2, CMD_AIR, CMD_FMT})
			next_rsp.bytes = LEN1;
		if (!(cmd.code inside {CMD_DEST, CMD_LEAD, CMD_TMO, CMD_ESC, CMD_HRATE, CMD_OUT1,
		    CMD_OUT2, CMD_AIR, CMD_FMT, CMD_RSSI, CMD_EXIT}))
			next_rsp.ok = 1'b0;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end else begin
			rsp_valid <= take;
			if (take)
				rsp <= next_rsp;
		end
	end

	// packet filter: vendor, then channel, then address
	wire vend_ok  = pkt.vendor == network_vendor_number;
	wire chan_ok  = vend_ok && pkt.channel == hopping_channel;
	wire [15:0] rx_addr = (own_address == ADDR_ALL) ? destination_address : own_address;
	wire addr_ok  = pkt.dest == ADDR_ALL || ((pkt.dest ^ rx_addr) & address_mask) == '0;
	wire accept   = pkt_valid && chan_ok && addr_ok;
	always_ff @(posedge clk) begin
		if (reset) begin
			pkt_accept  <= 1'b0;
			rssi_seen   <= 1'b0;
			rssi_mag    <= '0;
			last_accept <= 1'b0;
		end else begin
			pkt_accept <= accept;
			if (accept) begin
				rssi_seen   <= 1'b1;
				rssi_mag    <= pkt.power;
				last_accept <= 1'b1;
			end else if (pkt_valid) begin
				last_accept <= 1'b0;
			end
		end
	end
	// destination is the transmit address in both addressing schemes
	assign tx_address   = destination_address;
	assign tx_broadcast = destination_address == ADDR_ALL;

	// general-purpose output selection
	logic out1;
	logic out2;
	always_comb begin
		unique case (flow_output_one_select)
			3'd0:    out1 = host_stop; // cts low means clear to send
			3'd1:    out1 = !tx_active;
			3'd2:    out1 = 1'b1;
			3'd3:    out1 = tx_active;
			default: out1 = 1'b0;
		endcase
		unique case (status_output_two_select)
			3'd0:    out2 = rx_active;
			3'd1:    out2 = 1'b1;
			3'd4:    out2 = rx_active && last_accept;
			default: out2 = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			flow_output_one   <= 1'b0;
			status_output_two <= 1'b0;
		end else begin
			flow_output_one   <= out1;
			status_output_two <= out2;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_escape;
		state == ST_DATA && esc_hit;
	endsequence
	sequence s_after_guard;
		state == ST_ESC && !rx_valid && silence >= GUARD_AFTER;
	endsequence

	// the escape byte itself restarts silence, so arming and entry are checked as two steps
	a_escape_arms: assert property (s_escape |=> state == ST_ESC)
		else $error("escape byte did not arm the after-guard");
	a_enter_cmd_mode: assert property (s_after_guard |=> cmd_mode)
		else $error("command mode not entered after guard sequence");
	a_exit_cmd_leaves: assert property (is_exit |=> !cmd_mode ##0 rsp_valid && rsp.ok)
		else $error("exit command did not leave command mode");
	a_timeout_exits: assert property (cmd_mode && tmo_hit |=> !cmd_mode)
		else $error("inactivity timeout did not exit");
	a_idle_restarts: assert property (cmd_mode && rx_valid |=> idle == '0)
		else $error("host character did not restart timer");
	a_bad_rate_kept: assert property (take && cmd.write && cmd.code == CMD_HRATE && !rate_ok
		|=> $stable(host_rate_select) && rsp_valid && !rsp.ok)
		else $error("invalid host rate was stored");
	a_rate_waits_exit: assert property (!is_exit |=> $stable(host_divisor))
		else $error("host divisor changed without exit");
	a_rssi_marker: assert property (!rssi_seen && take && cmd.code == CMD_RSSI
		|=> rsp.data == {16'h0, RSSI_NONE})
		else $error("missing not-received marker");
	a_filter_order: assert property (pkt_accept |-> $past(pkt.vendor) == $past(network_vendor_number)
		&& $past(pkt.channel) == $past(hopping_channel))
		else $error("packet accepted past filters");
	a_payload_block: assert property (cmd_mode && rx_valid |=> !pay_valid)
		else $error("command byte leaked as payload");
	a_out2_reserved: assert property (status_output_two_select != OUT2_RSVD)
		else $error("reserved output two code stored");
	a_fmt_fixed_hex: assert property (take && hex_only |=> rsp.fmt == FMT_HEX)
		else $error("version or key not hexadecimal");
endmodule : rmc_config

// file: sim/rmc_config_tb_top.sv
// self-checking bench of the radio modem configuration block
`timescale 1ns/1ps
module rmc_config_tb_top;
	import rmc_pkg::*;
	localparam int TK = 8;
	logic        clk, reset, rx_valid, pay_valid, cmd_valid, rsp_valid, cmd_mode, pkt_valid, pkt_accept;
	logic        tx_broadcast, host_stop, tx_active, rx_active, flow_output_one, status_output_two, ex, la;
	logic [7:0]  rx_data, pay_data;
	logic [15:0] own_address, address_mask, network_vendor_number, tx_address, dst, o, m, a, v;
	logic [3:0]  hopping_channel, c;
	logic [31:0] host_divisor, air_rate, rnd, er;
	logic [2:0]  md;
	rmc_cmd_t    cmd;
	rmc_rsp_t    rsp;
	rmc_pkt_t    pkt, p;
	int          i, n_checks = 0, n_mismatch = 0;
	logic [7:0]  rc [10] = '{CMD_DEST, CMD_LEAD, CMD_TMO, CMD_ESC, CMD_HRATE, CMD_OUT1, CMD_OUT2, CMD_AIR, CMD_FMT, CMD_RSSI};
	logic [31:0] rv [10] = '{32'h0, 32'ha, 32'hc8, 32'h2b, 32'h3, 32'h0, 32'h2, 32'h1, 32'h1, 32'h8000};

	rmc_host_model #(.TICK(TK)) host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data));
	rmc_config #(.TICK_CYCLES(TK)) DUT (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
		.pay_valid(pay_valid), .pay_data(pay_data), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
		.rsp(rsp), .cmd_mode(cmd_mode), .host_divisor(host_divisor), .air_rate(air_rate), .pkt_valid(pkt_valid),
		.pkt(pkt), .own_address(own_address), .address_mask(address_mask), .network_vendor_number(network_vendor_number),
		.hopping_channel(hopping_channel), .pkt_accept(pkt_accept), .tx_address(tx_address),
		.tx_broadcast(tx_broadcast), .host_stop(host_stop), .tx_active(tx_active), .rx_active(rx_active),
		.flow_output_one(flow_output_one), .status_output_two(status_output_two));

	// expectations: divisor and stored literal rate both round to nearest
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] dv(input logic [31:0] r);
		return (32'd2500000 + r / 2) / r;
	endfunction : dv
	function automatic logic [2:0] nb(input logic [7:0] c);
		if (c == CMD_HRATE) return 3'd4;
		if (c inside {CMD_ESC, CMD_OUT1, CMD_OUT2, CMD_AIR, CMD_FMT}) return 3'd1;
		return 3'd2;
	endfunction : nb
	function automatic logic pin1(input logic [2:0] md, input logic hs, input logic ta);
		case (md)
			3'd0: return hs;
			3'd1: return ~ta;
			3'd2: return 1'b1;
			3'd3: return ta;
			default: return 1'b0;
		endcase
	endfunction : pin1
	function automatic logic pin2(input logic [2:0] md, input logic ra, input logic la);
		if (md == 3'd0) return ra;
		if (md == 3'd4) return ra & la;
		return md == 3'd1;
	endfunction : pin2

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// command held one edge; reply looked at in its single cycle
	task automatic cio(input logic w, input logic [7:0] c, input logic [31:0] d);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= {w, c, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1 chk("rsp_valid", 1'b1, rsp_valid);
	endtask : cio
	task automatic wr(input logic [7:0] c, input logic [31:0] d, input logic ok);
		cio(1'b1, c, d);
		chk("ok", ok, rsp.ok);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [31:0] e);
		cio(1'b0, c, 32'h0);
		chk("ok", 1'b1, rsp.ok);
		chk("bytes", nb(c), rsp.bytes);
		chk("data", e, rsp.data);
	endtask : rd
	// guard, escape, guard; no entry before the after-guard runs out
	task automatic enter();
		host.quiet(10);
		host.send(8'h2b);
		repeat (8 * TK) @(posedge clk);
		#1 chk("cmd_mode", 1'b0, cmd_mode);
		for (int k = 0; k < 200 && cmd_mode !== 1'b1; k++) @(posedge clk);
		#1 chk("cmd_mode", 1'b1, cmd_mode);
	endtask : enter
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// watchdog: whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		rnd = 32'hb977;
		{reset, cmd_valid, pkt_valid, host_stop, tx_active, rx_active} = 6'b100100;
		{cmd, pkt} = '0;
		{own_address, address_mask, network_vendor_number, hopping_channel} = {32'hffffffff, 16'h1234, 4'h3};
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("divisor", 32'd260, host_divisor);
		chk("air_rate", 32'd115200, air_rate);
		chk("flow_output_one", 1'b1, flow_output_one);
		chk("status_output_two", 1'b0, status_output_two);
		// commands outside command mode get no reply
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= {1'b1, CMD_AIR, 32'h0};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1 chk("rsp_valid", 1'b0, rsp_valid);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			host.send(rnd[7:0]);
			#1 chk("pay_data", {1'b1, rnd[7:0]}, {pay_valid, pay_data});
		end
		// a byte inside the after-guard aborts the entry
		host.quiet(10);
		host.send(8'h2b);
		repeat (2 * TK) @(posedge clk);
		host.send(8'h41);
		repeat (14 * TK) @(posedge clk);
		#1 chk("cmd_mode", 1'b0, cmd_mode);
		enter();
		for (i = 0; i < 10; i++) rd(rc[i], rv[i]);
		wr(CMD_RSSI, 32'h30, 1'b0);
		wr(CMD_ESC, 32'h1f, 1'b0);
		wr(CMD_ESC, 32'h80, 1'b0);
		wr(CMD_ESC, 32'h7f, 1'b1);
		rd(CMD_ESC, 32'h7f);
		wr(CMD_ESC, 32'h2b, 1'b1);
		wr(CMD_LEAD, 32'hffff, 1'b1);
		rd(CMD_LEAD, 32'hffff);
		wr(CMD_LEAD, 32'ha, 1'b1);
		wr(CMD_TMO, 32'h1, 1'b0);
		wr(CMD_AIR, 32'h0, 1'b1);
		chk("air_rate", 32'd9600, air_rate);
		wr(CMD_AIR, 32'h2, 1'b0);
		chk("air_rate", 32'd9600, air_rate);
		wr(CMD_AIR, 32'h1, 1'b1);
		for (i = 0; i < 3; i++) begin
			wr(CMD_FMT, i, 1'b1);
			cio(1'b0, CMD_RSSI, 32'h0);
			chk("fmt", i, rsp.fmt);
			cio(1'b0, i ? CMD_FWVER : CMD_KEY, 32'h0);
			chk("fmt", FMT_HEX, rsp.fmt);
		end
		wr(CMD_FMT, 32'h3, 1'b0);
		rd(CMD_FMT, 32'h2);
		wr(CMD_FMT, 32'h1, 1'b1);
		for (i = 0; i < 6; i++) begin
			wr(CMD_OUT1, i, i < 5);
			md = (i < 5) ? 3'(i) : 3'd4;
			rnd = lfsr(rnd);
			@(posedge clk);
			{host_stop, tx_active} <= rnd[1:0];
			repeat (2) @(posedge clk);
			#1 chk("flow_output_one", pin1(md, rnd[1], rnd[0]), flow_output_one);
		end
		// rate codes, the invalid gap, literals and the delayed switch
		for (i = 0; i < 9; i++) begin
			wr(CMD_HRATE, i, 1'b1);
			rd(CMD_HRATE, i);
		end
		wr(CMD_HRATE, 32'h09 + rnd % 48, 1'b0);
		wr(CMD_HRATE, 32'h38, 1'b0);
		wr(CMD_HRATE, 32'h1c9c39, 1'b0);
		rd(CMD_HRATE, 32'h8);
		wr(CMD_HRATE, 32'h39, 1'b1);
		rd(CMD_HRATE, dv(dv(32'h39)));
		wr(CMD_HRATE, 32'h1c9c38, 1'b1);
		rd(CMD_HRATE, dv(dv(32'h1c9c38)));
		wr(CMD_HRATE, 32'h1c200, 1'b1);
		rd(CMD_HRATE, dv(dv(32'h1c200)));
		chk("divisor", 32'd260, host_divisor);
		wr(CMD_EXIT, 32'h0, 1'b1);
		chk("cmd_mode", 1'b0, cmd_mode);
		chk("divisor", dv(dv(dv(32'h1c200))), host_divisor);
		host.send(8'h5a);
		#1 chk("pay_valid", 1'b1, pay_valid);
		enter();
		wr(CMD_DEST, 32'hffff, 1'b1);
		chk("tx_addr", {1'b1, 16'hffff}, {tx_broadcast, tx_address});
		dst = rnd[15:0] & 16'h7fff;
		wr(CMD_DEST, dst, 1'b1);
		chk("tx_addr", {1'b0, dst}, {tx_broadcast, tx_address});
		er = 32'h8000;
		for (i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			// vendor and channel filters move with every packet
			v = rnd[30:15];
			c = rnd[15:12];
			p = {rnd[0] ? v : rnd[31:16], rnd[1] ? c : rnd[7:4], 16'h0, 8'h28 + 8'(rnd % 71)};
			p.dest = rnd[2] ? 16'hffff : (rnd[3] ? dst : rnd[23:8]);
			o = rnd[4] ? 16'hffff : dst ^ {12'h0, rnd[11:8]};
			m = rnd[5] ? 16'hffff : 16'hfff0;
			a = (o == 16'hffff) ? dst : o;
			ex = p.vendor == v && p.channel == c && (p.dest == 16'hffff || ((p.dest ^ a) & m) == 16'h0);
			@(posedge clk);
			{pkt_valid, pkt, own_address, address_mask} <= {1'b1, p, o, m};
			{network_vendor_number, hopping_channel} <= {v, c};
			@(posedge clk);
			pkt_valid <= 1'b0;
			#1 chk("pkt_accept", ex, pkt_accept);
			la = ex;
			if (ex) er = {24'h0, p.power};
		end
		rd(CMD_RSSI, er);
		md = 3'd2;
		for (i = 0; i < 6; i++) begin
			wr(CMD_OUT2, i, i != 3 && i < 5);
			if (i != 3 && i < 5) md = 3'(i);
			rnd = lfsr(rnd);
			@(posedge clk);
			rx_active <= rnd[0];
			repeat (2) @(posedge clk);
			#1 chk("status_output_two", pin2(md, rnd[0], la), status_output_two);
		end
		// host bytes keep the shortest timeout from expiring
		wr(CMD_TMO, 32'h2, 1'b1);
		for (i = 0; i < 6; i++) begin
			repeat (3) @(posedge clk);
			host.send(8'h55);
			#1 chk("pay_cmd", 2'b01, {pay_valid, cmd_mode});
		end
		repeat (4) @(posedge clk);
		#1 chk("cmd_mode", 1'b1, cmd_mode);
		repeat (4 * TK) @(posedge clk);
		#1 chk("cmd_mode", 1'b0, cmd_mode);
		conclude();
	end
endmodule : rmc_config_tb_top

// file: sim/rmc_host_model.sv
// host side model: serial bytes and guard silences
`timescale 1ns/1ps
module rmc_host_model #(
	parameter int TICK = 8
) (
	input  wire logic clk,
	output logic      rx_valid,
	output logic [7:0] rx_data
);
	// lines idle at time zero
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// one byte per call, released after the edge that takes it
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b; // stale byte must not look valid
	endtask : send
	// silence of n guard ticks, two spare ticks for tick phase
	task automatic quiet(input int n);
		repeat ((n + 2) * TICK) @(posedge clk);
	endtask : quiet
endmodule : rmc_host_model
